// ### core/xcvr_pkg.sv
package xcvr_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int SECTION_WIDTH = 9;
    localparam int SECTION_COUNT = 2;
    localparam int PATH_WIDTH = SECTION_WIDTH * SECTION_COUNT;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PATH_WIDTH-1:0] STORE_RESET = 18'h00000;
    localparam logic [1:0] CE_N_RESET = 2'h3;
    localparam logic OE_N_RESET = 1'b1;
    localparam logic READY_RESET = 1'b0;
    localparam logic CLK_SAMPLE_RESET = 1'b0;

    // ------------------------------------------------------------
    // Per-direction controls
    // ------------------------------------------------------------
    typedef struct packed {
        logic output_enable_n;
        logic [SECTION_COUNT-1:0] capture_enable_n;
    } dir_ctrl_type;

    typedef enum logic [0:0] {
        SIDE_A,
        SIDE_B
    } side_type;

endpackage : xcvr_pkg

// ### core/stream_fifo.sv
`timescale 1ns/1ps

module stream_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // Pointers
    // ------------------------------------------------------------
    always_comb begin
        push = i_in_valid && (count != (AW+1)'(DEPTH));
        pop = (count != '0) && i_out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage has no reset; contents are only read once written
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    assign o_in_ready = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];

endmodule : stream_fifo

// ### core/bus_transceiver.sv
`timescale 1ns/1ps

// What this block does
// - Eighteen bits each way, two nine-bit sections with their own storage.
// - Rising clock edge with capture enable low stores input; output shows it.
// - Capture enable high holds stored value through clock edges.
// - No rising edge means stored level stays on enabled outputs.
// - Output enable high puts outputs in isolation regardless of everything.
// - Output enable low drives stored contents onto the outputs.
// - B-to-A path has its own clock and enables but bypasses the FIFO, storing one cycle sooner.
// - Each nine-bit section captures or holds independently.
module bus_transceiver #(
    parameter int SECTION_WIDTH = xcvr_pkg::SECTION_WIDTH,
    parameter int FIFO_DEPTH = xcvr_pkg::FIFO_DEPTH
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    input wire logic I_A_TO_B_CLK,
    input wire logic [1:0] I_A_TO_B_CAPTURE_ENABLE_N,
    input wire logic I_A_TO_B_OUTPUT_ENABLE_N,
    input wire logic I_B_TO_A_CLK,
    input wire logic [1:0] I_B_TO_A_CAPTURE_ENABLE_N,
    input wire logic I_B_TO_A_OUTPUT_ENABLE_N,
    input wire logic [2*SECTION_WIDTH-1:0] I_A_IN,
    output logic [2*SECTION_WIDTH-1:0] O_A_OUT,
    output logic O_A_OE_N,
    input wire logic [2*SECTION_WIDTH-1:0] I_B_IN,
    output logic [2*SECTION_WIDTH-1:0] O_B_OUT,
    output logic O_B_OE_N,
    output logic O_A_TO_B_FIFO_READY
);

    localparam int W = 2 * SECTION_WIDTH;

    typedef struct packed {
        logic [W-1:0] data;
        logic [1:0] ce_n;
    } capture_type;

    // ------------------------------------------------------------
    // Edge detection of the direction clocks
    // ------------------------------------------------------------
    logic ab_clk_q;
    logic ba_clk_q;
    logic ab_rise;
    logic ba_rise;

    // Pin clocks are sampled as ordinary synchronous inputs
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ab_clk_q <= xcvr_pkg::CLK_SAMPLE_RESET;
            ba_clk_q <= xcvr_pkg::CLK_SAMPLE_RESET;
        end else begin
            ab_clk_q <= I_A_TO_B_CLK;
            ba_clk_q <= I_B_TO_A_CLK;
        end
    end

    assign ab_rise = I_A_TO_B_CLK && !ab_clk_q;
    assign ba_rise = I_B_TO_A_CLK && !ba_clk_q;

    // ------------------------------------------------------------
    // A-to-B capture path through the FIFO
    // ------------------------------------------------------------
    capture_type ab_in;
    capture_type ab_out;
    logic ab_in_ready;
    logic ab_out_valid;

    assign ab_in = '{data: I_A_IN, ce_n: I_A_TO_B_CAPTURE_ENABLE_N};

    // Buffering adds latency but keeps edge order; full drops an edge
    stream_fifo #(
        .WIDTH($bits(capture_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_ab_fifo (
        .i_clk(I_CLK_SYS),
        .i_reset_n(I_RESET_N),
        .i_in_valid(ab_rise && (I_A_TO_B_CAPTURE_ENABLE_N != 2'h3)),
        .o_in_ready(ab_in_ready),
        .i_in_data(ab_in),
        .o_out_valid(ab_out_valid),
        .i_out_ready(1'b1),
        .o_out_data(ab_out)
    );

    // ------------------------------------------------------------
    // Storage registers
    // ------------------------------------------------------------
    logic [W-1:0] ab_store;
    logic [W-1:0] ba_store;
    logic [W-1:0] next_ab_store;
    logic [W-1:0] next_ba_store;

    function automatic logic [W-1:0] capture(
        input logic [W-1:0] store,
        input logic [W-1:0] data,
        input logic [1:0] ce_n,
        input logic strobe
    );
        logic [W-1:0] result;
        result = store;
        for (int s = 0; s < 2; s++) begin
            if (strobe && !ce_n[s]) begin
                result[s*SECTION_WIDTH +: SECTION_WIDTH] =
                    data[s*SECTION_WIDTH +: SECTION_WIDTH];
            end
        end
        return result;
    endfunction : capture

    always_comb begin
        next_ab_store = capture(ab_store, ab_out.data, ab_out.ce_n, ab_out_valid);
        next_ba_store = capture(ba_store, I_B_IN, I_B_TO_A_CAPTURE_ENABLE_N,
            ba_rise);
    end

    // Reset constant only stands in for undefined power-up contents
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ab_store <= xcvr_pkg::STORE_RESET;
            ba_store <= xcvr_pkg::STORE_RESET;
        end else begin
            ab_store <= next_ab_store;
            ba_store <= next_ba_store;
        end
    end

    // ------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------
    logic [W-1:0] b_out;
    logic [W-1:0] a_out;
    logic b_oe_n;
    logic a_oe_n;
    logic fifo_ready;

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            b_out <= xcvr_pkg::STORE_RESET;
            a_out <= xcvr_pkg::STORE_RESET;
            b_oe_n <= xcvr_pkg::OE_N_RESET;
            a_oe_n <= xcvr_pkg::OE_N_RESET;
            fifo_ready <= xcvr_pkg::READY_RESET;
        end else begin
            b_out <= next_ab_store;
            a_out <= next_ba_store;
            b_oe_n <= I_A_TO_B_OUTPUT_ENABLE_N;
            a_oe_n <= I_B_TO_A_OUTPUT_ENABLE_N;
            fifo_ready <= ab_in_ready;
        end
    end

    assign O_B_OUT = b_out;
    assign O_A_OUT = a_out;
    assign O_B_OE_N = b_oe_n;
    assign O_A_OE_N = a_oe_n;
    assign O_A_TO_B_FIFO_READY = fifo_ready;

endmodule : bus_transceiver

// ### testbench/xcvr_check_sva.sv
`timescale 1ns/1ps
module xcvr_check #(
    parameter int SECTION_WIDTH = 9
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    input wire logic I_A_TO_B_CLK,
    input wire logic [1:0] I_A_TO_B_CAPTURE_ENABLE_N,
    input wire logic I_A_TO_B_OUTPUT_ENABLE_N,
    input wire logic I_B_TO_A_CLK,
    input wire logic [1:0] I_B_TO_A_CAPTURE_ENABLE_N,
    input wire logic I_B_TO_A_OUTPUT_ENABLE_N,
    input wire logic [2*SECTION_WIDTH-1:0] I_A_IN,
    input wire logic [2*SECTION_WIDTH-1:0] O_A_OUT,
    input wire logic O_A_OE_N,
    input wire logic [2*SECTION_WIDTH-1:0] I_B_IN,
    input wire logic [2*SECTION_WIDTH-1:0] O_B_OUT,
    input wire logic O_B_OE_N,
    input wire logic O_A_TO_B_FIFO_READY
);
    localparam int W = SECTION_WIDTH;
    // ----
    // Checks
    // ----
    default clocking dc @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESET_N);
    a_b_enable_lag: assert property ($past(I_RESET_N)
        |-> O_B_OE_N == $past(I_A_TO_B_OUTPUT_ENABLE_N)) else $error("B enable");
    a_a_enable_lag: assert property ($past(I_RESET_N)
        |-> O_A_OE_N == $past(I_B_TO_A_OUTPUT_ENABLE_N)) else $error("A enable");
    a_ab_take_lo: assert property ($rose(I_A_TO_B_CLK) && !I_A_TO_B_CAPTURE_ENABLE_N[0]
        |-> ##2 O_B_OUT[W-1:0] == $past(I_A_IN[W-1:0], 2)) else $error("AB take");
    a_ba_take_lo: assert property ($rose(I_B_TO_A_CLK) && !I_B_TO_A_CAPTURE_ENABLE_N[0]
        |=> O_A_OUT[W-1:0] == $past(I_B_IN[W-1:0])) else $error("BA take");
    a_ba_take_hi: assert property ($rose(I_B_TO_A_CLK) && !I_B_TO_A_CAPTURE_ENABLE_N[1]
        |=> O_A_OUT[2*W-1:W] == $past(I_B_IN[2*W-1:W])) else $error("BA take hi");
    a_ba_hold_lo: assert property ($past(I_RESET_N)
        && (!$rose(I_B_TO_A_CLK) || I_B_TO_A_CAPTURE_ENABLE_N[0])
        |=> $stable(O_A_OUT[W-1:0])) else $error("BA hold");
    a_ab_hold_hi: assert property ((!$rose(I_A_TO_B_CLK) || I_A_TO_B_CAPTURE_ENABLE_N[1])
        |-> ##2 $stable(O_B_OUT[2*W-1:W])) else $error("AB hold");
    a_ready_high: assert property ($past(I_RESET_N) |-> O_A_TO_B_FIFO_READY)
        else $error("ready");
    c_ab_part: cover property ($rose(I_A_TO_B_CLK) && I_A_TO_B_CAPTURE_ENABLE_N == 2'h2);
    c_ba_part: cover property ($rose(I_B_TO_A_CLK) && I_B_TO_A_CAPTURE_ENABLE_N == 2'h1);
    c_isolate: cover property ($rose(O_B_OE_N));
endmodule : xcvr_check
bind bus_transceiver xcvr_check #(.SECTION_WIDTH(SECTION_WIDTH)) xcvr_check_inst (.*);

// ### testbench/backplane_model.sv
`timescale 1ns/1ps
module backplane_model (
    input wire logic i_drive_en,
    input wire logic [17:0] i_drive_data,
    input wire logic [17:0] i_dev_out,
    input wire logic i_dev_oe_n,
    output logic [17:0] o_level
);
    // ----
    // Terminated bus, released lines pull high
    // ----
    always_comb begin
        if (!i_dev_oe_n) begin
            o_level = i_dev_out;
        end else if (i_drive_en) begin
            o_level = i_drive_data;
        end else begin
            o_level = 18'h3FFFF;
        end
    end
endmodule : backplane_model

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
    // ----
    // Names match the ports so one implicit hookup serves
    // ----
    logic I_CLK_SYS = 1'b0;
    logic I_RESET_N = 1'b0;
    logic I_A_TO_B_CLK = 1'b0;
    logic I_B_TO_A_CLK = 1'b0;
    logic I_A_TO_B_OUTPUT_ENABLE_N = 1'b1;
    logic I_B_TO_A_OUTPUT_ENABLE_N = 1'b1;
    logic [1:0] I_A_TO_B_CAPTURE_ENABLE_N = 2'h3;
    logic [1:0] I_B_TO_A_CAPTURE_ENABLE_N = 2'h3;
    logic [17:0] I_A_IN = 18'h00000;
    logic [17:0] bp_data = 18'h00000;
    logic bp_en = 1'b0;
    logic [17:0] O_A_OUT, O_B_OUT, I_B_IN;
    logic O_A_OE_N, O_B_OE_N, O_A_TO_B_FIFO_READY;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    bus_transceiver bus_transceiver_inst (.*);
    backplane_model backplane_model_inst (.i_drive_en(bp_en), .i_drive_data(bp_data),
        .i_dev_out(O_B_OUT), .i_dev_oe_n(O_B_OE_N), .o_level(I_B_IN));
    initial begin
        forever #5 I_CLK_SYS = ~I_CLK_SYS;
    end
    task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic pulse(input logic ab, input logic [1:0] ce, input logic [17:0] d);
        @(negedge I_CLK_SYS);
        if (ab) begin
            I_A_TO_B_CAPTURE_ENABLE_N = ce;
            I_A_IN = d;
            I_A_TO_B_CLK = 1'b1;
        end else begin
            I_B_TO_A_CAPTURE_ENABLE_N = ce;
            bp_data = d;
            I_B_TO_A_CLK = 1'b1;
        end
        @(negedge I_CLK_SYS);
        I_A_TO_B_CLK = 1'b0;
        I_B_TO_A_CLK = 1'b0;
        repeat (2) @(negedge I_CLK_SYS);
    endtask : pulse
    task automatic t_ab_path();
        I_A_TO_B_OUTPUT_ENABLE_N = 1'b0;
        pulse(1'b1, 2'h0, 18'h2A5C3);
        check("b_out", 18'h2A5C3, O_B_OUT);
        check("b_wire", 18'h2A5C3, I_B_IN);
        pulse(1'b1, 2'h2, 18'h15A3C);
        check("b_out", 18'h2A43C, O_B_OUT);
        pulse(1'b1, 2'h3, 18'h3FFFF);
        check("b_out", 18'h2A43C, O_B_OUT);
        I_A_IN = 18'h00000;
        I_A_TO_B_CAPTURE_ENABLE_N = 2'h0;
        repeat (4) @(negedge I_CLK_SYS);
        check("b_out", 18'h2A43C, O_B_OUT);
        // Clock held high: a level, not an edge, must not store
        I_A_TO_B_CAPTURE_ENABLE_N = 2'h3;
        I_A_TO_B_CLK = 1'b1;
        repeat (2) @(negedge I_CLK_SYS);
        I_A_TO_B_CAPTURE_ENABLE_N = 2'h0;
        repeat (4) @(negedge I_CLK_SYS);
        check("b_out", 18'h2A43C, O_B_OUT);
        I_A_TO_B_CLK = 1'b0;
    endtask : t_ab_path
    task automatic t_ab_isolate();
        I_A_TO_B_OUTPUT_ENABLE_N = 1'b1;
        pulse(1'b1, 2'h0, 18'h00155);
        check("b_oe_n", 18'h00001, {17'h00000, O_B_OE_N});
        check("b_wire", 18'h3FFFF, I_B_IN);
        I_A_TO_B_OUTPUT_ENABLE_N = 1'b0;
        repeat (2) @(negedge I_CLK_SYS);
        check("b_wire", 18'h00155, I_B_IN);
    endtask : t_ab_isolate
    task automatic t_ba_path();
        I_A_TO_B_OUTPUT_ENABLE_N = 1'b1;
        bp_en = 1'b1;
        I_B_TO_A_OUTPUT_ENABLE_N = 1'b0;
        pulse(1'b0, 2'h0, 18'h3C00F);
        check("a_out", 18'h3C00F, O_A_OUT);
        check("a_oe_n", 18'h00000, {17'h00000, O_A_OE_N});
        pulse(1'b0, 2'h1, 18'h003FF);
        check("a_out", 18'h0020F, O_A_OUT);
        I_B_TO_A_OUTPUT_ENABLE_N = 1'b1;
        repeat (2) @(negedge I_CLK_SYS);
        check("a_oe_n", 18'h00001, {17'h00000, O_A_OE_N});
    endtask : t_ba_path
    task automatic t_reset();
        I_A_TO_B_OUTPUT_ENABLE_N = 1'b0;
        I_B_TO_A_OUTPUT_ENABLE_N = 1'b0;
        @(negedge I_CLK_SYS);
        I_RESET_N = 1'b0;
        @(negedge I_CLK_SYS);
        check("b_out", xcvr_pkg::STORE_RESET, O_B_OUT);
        check("a_out", xcvr_pkg::STORE_RESET, O_A_OUT);
        check("b_oe_n", 18'h00001, {17'h00000, O_B_OE_N});
        check("a_oe_n", 18'h00001, {17'h00000, O_A_OE_N});
        check("ready", 18'h00000, {17'h00000, O_A_TO_B_FIFO_READY});
        repeat (3) @(negedge I_CLK_SYS);
        I_RESET_N = 1'b1;
        repeat (2) @(negedge I_CLK_SYS);
        check("ready", 18'h00001, {17'h00000, O_A_TO_B_FIFO_READY});
        check("b_oe_n", 18'h00000, {17'h00000, O_B_OE_N});
        I_A_TO_B_OUTPUT_ENABLE_N = 1'b1;
        pulse(1'b0, 2'h0, 18'h1E2D4);
        check("a_out", 18'h1E2D4, O_A_OUT);
        check("a_oe_n", 18'h00000, {17'h00000, O_A_OE_N});
    endtask : t_reset
    task automatic end_sim();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // Generous ceiling: the whole run needs well under a hundred cycles
    always @(posedge I_CLK_SYS) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        repeat (20) @(negedge I_CLK_SYS);
        I_RESET_N = 1'b1;
        repeat (2) @(negedge I_CLK_SYS);
        t_ab_path();
        t_ab_isolate();
        t_ba_path();
        t_reset();
        end_sim();
    end
endmodule : tb
